// ===== hdl/bcg_pkg.sv
// Shared constants, types and helper functions for the message gap timing block.
package bcg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  BCG_CTRL_OFS      = 8'h00;
    localparam logic [7:0]  BCG_SETUP6_OFS    = 8'h04;
    localparam logic [7:0]  BCG_GAP_EXT_OFS   = 8'h08;
    localparam logic [7:0]  BCG_STATUS_OFS    = 8'h0C;

    localparam int unsigned BCG_CTRL_SEQ_POS  = 0;
    localparam int unsigned BCG_CTRL_CLK_POS  = 1;
    localparam int unsigned BCG_CTRL_TO_POS   = 3;
    localparam int unsigned BCG_SETUP6_PRIO_POS = 14;
    localparam int unsigned BCG_STAT_TO_POS   = 0;
    localparam int unsigned BCG_STAT_BUSY_POS = 1;
    localparam int unsigned BCG_STAT_EXTRA_POS = 8;

    localparam logic [4:0]  BCG_CTRL_RST      = 5'h00;
    localparam logic        BCG_PRIO_RST      = 1'b0;
    localparam logic [15:0] BCG_GAP_EXT_RST   = 16'h0000;

    localparam logic [1:0]  BCG_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  BCG_RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [2:0]  BCG_OPEN_XFERS    = 3'h7;
    localparam logic [2:0]  BCG_CLOSE_XFERS   = 3'h5;
    localparam logic [6:0]  BCG_HOST_ACC_CYC  = 7'h06;
    localparam logic [6:0]  BCG_SEQ_MODE_CYC  = 7'h0A;
    localparam logic [6:0]  BCG_GAP_BASE_CYC  = 7'h14;

    // No-response timeouts in nanoseconds, counted in half-microsecond ticks.
    localparam int unsigned BCG_HALF_US_NS    = 500;
    localparam int unsigned BCG_TO0_NS        = 18500;
    localparam int unsigned BCG_TO1_NS        = 22500;
    localparam int unsigned BCG_TO2_NS        = 50500;
    localparam int unsigned BCG_TO3_NS        = 128000;

    typedef enum logic [1:0] {
        BCG_CLK_10,
        BCG_CLK_12,
        BCG_CLK_16,
        BCG_CLK_20
    } bcg_clk_sel_t;

    // Software settings steering the timing logic.
    typedef struct packed {
        logic         seq_mode;
        bcg_clk_sel_t clk_sel;
        logic [1:0]   to_sel;
        logic         host_prio;
        logic [15:0]  gap_ext;
    } bcg_cfg_t;

    // System clock cycles in one half microsecond.
    function automatic logic [3:0] bcg_half_us_cyc(input bcg_clk_sel_t sel);
        unique case (sel)
            BCG_CLK_10: bcg_half_us_cyc = 4'h5;
            BCG_CLK_12: bcg_half_us_cyc = 4'h6;
            BCG_CLK_16: bcg_half_us_cyc = 4'h8;
            BCG_CLK_20: bcg_half_us_cyc = 4'hA;
        endcase
    endfunction

    // Timeout length in half-microsecond ticks.
    function automatic logic [8:0] bcg_to_ticks(input logic [1:0] sel);
        unique case (sel)
            2'h0:    bcg_to_ticks = 9'(BCG_TO0_NS / BCG_HALF_US_NS);
            2'h1:    bcg_to_ticks = 9'(BCG_TO1_NS / BCG_HALF_US_NS);
            2'h2:    bcg_to_ticks = 9'(BCG_TO2_NS / BCG_HALF_US_NS);
            default: bcg_to_ticks = 9'(BCG_TO3_NS / BCG_HALF_US_NS);
        endcase
    endfunction

    // Fixed part of the gap: base, sequenced mode surcharge, host accesses.
    function automatic logic [7:0] bcg_fix_len(input logic seq, input logic [6:0] extra);
        bcg_fix_len = {1'b0, BCG_GAP_BASE_CYC} + {1'b0, (seq ? BCG_SEQ_MODE_CYC : 7'h00)} + {1'b0, extra};
    endfunction

endpackage

// ===== hdl/bcg_tick.sv
// Half-microsecond and microsecond tick generator for the selected system clock.
`timescale 1ns/100ps
module bcg_tick (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    // Frequency selection
    input  wire bcg_pkg::bcg_clk_sel_t clk_sel_in,
    // Ticks
    output logic                       half_tick_out,
    output logic                       us_tick_out
);
    import bcg_pkg::*;

    typedef struct packed {
        logic [3:0] div;
        logic       odd;
        logic       half;
        logic       us;
    } bcg_tick_st_t;

    bcg_tick_st_t st_reg;
    bcg_tick_st_t st_next;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_comb begin
        st_next      = st_reg;
        st_next.half = 1'b0;
        st_next.us   = 1'b0;
        if (st_reg.div >= bcg_half_us_cyc(clk_sel_in) - 4'h1) begin
            st_next.div  = 4'h0;
            st_next.half = 1'b1;
            st_next.us   = st_reg.odd;
            st_next.odd  = ~st_reg.odd;
        end else begin
            st_next.div = st_reg.div + 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign half_tick_out = st_reg.half;
    assign us_tick_out   = st_reg.us;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [4:0]   since_us;
    bcg_clk_sel_t sel_seen;
    always_ff @(posedge clk_in) begin
        sel_seen <= clk_sel_in;
        // A frequency change leaves the running spacing meaningless, so it is marked unknown.
        if (!rst_n_in || clk_sel_in != sel_seen) begin
            since_us <= 5'h1F;
        end else if (us_tick_out) begin
            since_us <= 5'h01;
        end else if (since_us != 5'h1F) begin
            since_us <= since_us + 5'h01;
        end
    end

    a_us_period: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (us_tick_out && since_us != 5'h1F) |-> since_us == {bcg_half_us_cyc(clk_sel_in), 1'b0})
        else $error("Microsecond tick spacing does not match the selected clock.");
    a_us_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (us_tick_out && $stable(clk_sel_in)) |=> !us_tick_out [*2])
        else $error("Microsecond ticks too close together.");

endmodule // bcg_tick

// ===== hdl/bcg_gap_timer.sv
// Intermessage gap timer with host access insertion, no-response timeout and AXI4-Lite registers.
`timescale 1ns/100ps
module bcg_gap_timer (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [7:0]  s_axi_awaddr_in,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    // AXI4-Lite write response
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    output logic [1:0]       s_axi_bresp_out,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    input  wire logic [7:0]  s_axi_araddr_in,
    // AXI4-Lite read data
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    // Message sequencing
    input  wire logic        msg_start_in,
    input  wire logic        msg_end_in,
    output logic             in_sequence_out,
    output logic             gap_done_out,
    // Host memory access arbitration
    input  wire logic        host_req_in,
    output logic             host_grant_out,
    // No-response timer
    input  wire logic        resp_start_in,
    input  wire logic        resp_seen_in,
    output logic             timeout_out
);
    import bcg_pkg::*;

    typedef enum logic [2:0] {
        BCG_IDLE,
        BCG_OPEN,
        BCG_MSG,
        BCG_CLOSE,
        BCG_GAP_FIX,
        BCG_GAP_US
    } bcg_state_t;

    typedef struct packed {
        bcg_state_t  st;
        logic [2:0]  xfer;
        logic [6:0]  extra;
        logic [7:0]  fix_cnt;
        logic [15:0] us_cnt;
        logic        gap_done;
        logic        grant;
        logic        in_seq;
        logic        to_run;
        logic [8:0]  to_cnt;
        logic        to_pulse;
        logic        to_flag;
        bcg_cfg_t    cfg;
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } bcg_state_s_t;

    bcg_state_s_t st_reg;
    bcg_state_s_t st_next;
    logic         half_tick;
    logic         us_tick;

    function automatic logic [31:0] bcg_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            bcg_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    bcg_tick u_tick (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .clk_sel_in    (st_reg.cfg.clk_sel),
        .half_tick_out (half_tick),
        .us_tick_out   (us_tick)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        in_seq_now;
        logic        to_set;
        logic [31:0] wv;
        logic [31:0] ctrl_word;
        in_seq_now = 1'b0;
        to_set     = 1'b0;
        wv         = 32'h0000_0000;
        ctrl_word  = 32'h0000_0000;
        st_next           = st_reg;
        st_next.gap_done  = 1'b0;
        st_next.grant     = 1'b0;
        st_next.to_pulse  = 1'b0;

        // Message sequencer and gap.
        in_seq_now = (st_reg.st == BCG_OPEN) || (st_reg.st == BCG_CLOSE);
        if (host_req_in && !st_reg.grant && (!in_seq_now || st_reg.cfg.host_prio)) begin
            st_next.grant = 1'b1;
            if (in_seq_now) begin
                st_next.extra = st_reg.extra + BCG_HOST_ACC_CYC;
            end
        end
        unique case (st_reg.st)
            BCG_IDLE: begin
                if (msg_start_in) begin
                    st_next.st    = BCG_OPEN;
                    st_next.xfer  = 3'h1;
                    st_next.extra = 7'h00;
                end
            end
            BCG_OPEN: begin
                st_next.xfer = st_reg.xfer + 3'h1;
                if (st_reg.xfer == BCG_OPEN_XFERS) begin
                    st_next.st = BCG_MSG;
                end
            end
            BCG_MSG: begin
                if (msg_end_in) begin
                    st_next.st   = BCG_CLOSE;
                    st_next.xfer = 3'h1;
                end
            end
            BCG_CLOSE: begin
                st_next.xfer = st_reg.xfer + 3'h1;
                if (st_reg.xfer == BCG_CLOSE_XFERS) begin
                    st_next.st      = BCG_GAP_FIX;
                    st_next.fix_cnt = bcg_fix_len(st_reg.cfg.seq_mode, st_next.extra);
                end
            end
            BCG_GAP_FIX: begin
                st_next.fix_cnt = st_reg.fix_cnt - 8'h01;
                if (st_reg.fix_cnt == 8'h01) begin
                    st_next.st     = BCG_GAP_US;
                    st_next.us_cnt = st_reg.cfg.gap_ext;
                end
            end
            BCG_GAP_US: begin
                if (st_reg.us_cnt == 16'h0000) begin
                    st_next.st       = BCG_IDLE;
                    st_next.gap_done = 1'b1;
                end else if (us_tick) begin
                    st_next.us_cnt = st_reg.us_cnt - 16'h0001;
                end
            end
        endcase
        st_next.in_seq = (st_next.st == BCG_OPEN) || (st_next.st == BCG_CLOSE);

        // No-response timer, counted in half microseconds so it holds at any clock.
        if (resp_start_in) begin
            st_next.to_run = 1'b1;
            st_next.to_cnt = 9'h000;
        end else if (st_reg.to_run) begin
            if (resp_seen_in) begin
                st_next.to_run = 1'b0;
            end else if (half_tick) begin
                st_next.to_cnt = st_reg.to_cnt + 9'h001;
                if (st_reg.to_cnt + 9'h001 >= bcg_to_ticks(st_reg.cfg.to_sel)) begin
                    st_next.to_run   = 1'b0;
                    st_next.to_pulse = 1'b1;
                    to_set           = 1'b1;
                end
            end
        end

        // AXI4-Lite write path: address and data may arrive in either order.
        if (s_axi_awvalid_in && st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.wdata  = s_axi_wdata_in;
            st_next.wstrb  = s_axi_wstrb_in;
        end
        if (st_reg.bvalid && s_axi_bready_in) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = BCG_RESP_OKAY;
            ctrl_word = {27'h0, st_reg.cfg.to_sel, st_reg.cfg.clk_sel, st_reg.cfg.seq_mode};
            unique case (st_reg.aw_addr[7:2])
                BCG_CTRL_OFS[7:2]: begin
                    wv = bcg_merge(ctrl_word, st_reg.wdata, st_reg.wstrb);
                    st_next.cfg.seq_mode = wv[BCG_CTRL_SEQ_POS];
                    st_next.cfg.clk_sel  = bcg_clk_sel_t'(wv[BCG_CTRL_CLK_POS +: 2]);
                    st_next.cfg.to_sel   = wv[BCG_CTRL_TO_POS +: 2];
                end
                BCG_SETUP6_OFS[7:2]: begin
                    if (st_reg.wstrb[BCG_SETUP6_PRIO_POS / 8]) begin
                        st_next.cfg.host_prio = st_reg.wdata[BCG_SETUP6_PRIO_POS];
                    end
                end
                BCG_GAP_EXT_OFS[7:2]: begin
                    wv = bcg_merge({16'h0, st_reg.cfg.gap_ext}, st_reg.wdata, st_reg.wstrb);
                    st_next.cfg.gap_ext = wv[15:0];
                end
                BCG_STATUS_OFS[7:2]: begin
                    // Write one to clear; a timeout in the same cycle keeps the flag.
                    if (st_reg.wstrb[0] && st_reg.wdata[BCG_STAT_TO_POS]) begin
                        st_next.to_flag = 1'b0;
                    end
                end
                default: st_next.bresp = BCG_RESP_SLVERR;
            endcase
        end
        if (to_set) begin
            st_next.to_flag = 1'b1;
        end
        st_next.awready = !st_next.aw_have && !st_next.bvalid;
        st_next.wready  = !st_next.w_have && !st_next.bvalid;

        // AXI4-Lite read path.
        if (st_reg.rvalid && s_axi_rready_in) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = BCG_RESP_OKAY;
            st_next.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr_in[7:2])
                BCG_CTRL_OFS[7:2]:
                    st_next.rdata = {27'h0, st_reg.cfg.to_sel, st_reg.cfg.clk_sel, st_reg.cfg.seq_mode};
                BCG_SETUP6_OFS[7:2]:
                    st_next.rdata[BCG_SETUP6_PRIO_POS] = st_reg.cfg.host_prio;
                BCG_GAP_EXT_OFS[7:2]:
                    st_next.rdata = {16'h0, st_reg.cfg.gap_ext};
                BCG_STATUS_OFS[7:2]: begin
                    st_next.rdata[BCG_STAT_TO_POS]          = st_reg.to_flag;
                    st_next.rdata[BCG_STAT_BUSY_POS]        = (st_reg.st != BCG_IDLE);
                    st_next.rdata[BCG_STAT_EXTRA_POS +: 7]  = st_reg.extra;
                end
                default: st_next.rresp = BCG_RESP_SLVERR;
            endcase
        end
        st_next.arready = !st_next.rvalid;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_reg               <= '0;
            st_reg.st            <= BCG_IDLE;
            st_reg.cfg.seq_mode  <= BCG_CTRL_RST[BCG_CTRL_SEQ_POS];
            st_reg.cfg.clk_sel   <= bcg_clk_sel_t'(BCG_CTRL_RST[BCG_CTRL_CLK_POS +: 2]);
            st_reg.cfg.to_sel    <= BCG_CTRL_RST[BCG_CTRL_TO_POS +: 2];
            st_reg.cfg.host_prio <= BCG_PRIO_RST;
            st_reg.cfg.gap_ext   <= BCG_GAP_EXT_RST;
            st_reg.awready       <= 1'b1;
            st_reg.wready        <= 1'b1;
            st_reg.arready       <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready_out = st_reg.awready;
    assign s_axi_wready_out  = st_reg.wready;
    assign s_axi_bvalid_out  = st_reg.bvalid;
    assign s_axi_bresp_out   = st_reg.bresp;
    assign s_axi_arready_out = st_reg.arready;
    assign s_axi_rvalid_out  = st_reg.rvalid;
    assign s_axi_rdata_out   = st_reg.rdata;
    assign s_axi_rresp_out   = st_reg.rresp;
    assign in_sequence_out   = st_reg.in_seq;
    assign gap_done_out      = st_reg.gap_done;
    assign host_grant_out    = st_reg.grant;
    assign timeout_out       = st_reg.to_pulse;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking bcg_cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_open_length: assert property ((st_reg.st == BCG_IDLE && msg_start_in)
        |=> (st_reg.st == BCG_OPEN) [*7] ##1 (st_reg.st == BCG_MSG))
        else $error("Opening sequence is not seven transfers long.");
    a_close_length: assert property ((st_reg.st == BCG_MSG && msg_end_in)
        |=> (st_reg.st == BCG_CLOSE) [*5] ##1 (st_reg.st == BCG_GAP_FIX))
        else $error("Closing sequence is not five transfers long.");
    a_prio_holdoff: assert property ((in_sequence_out && !st_reg.cfg.host_prio)
        |=> !host_grant_out)
        else $error("Host granted during a sequence without priority.");
    a_access_cost: assert property ((host_grant_out && $past(st_reg.in_seq) && $past(st_reg.st) != BCG_IDLE
        && $past(st_reg.st) != BCG_MSG && $past(st_reg.st) != BCG_GAP_FIX)
        |-> st_reg.extra == $past(st_reg.extra) + BCG_HOST_ACC_CYC)
        else $error("Sequence access did not add six cycles.");
    a_fix_plain: assert property (($rose(st_reg.st == BCG_GAP_FIX) && !st_reg.cfg.seq_mode)
        |-> st_reg.fix_cnt == {1'b0, BCG_GAP_BASE_CYC} + {1'b0, st_reg.extra})
        else $error("Plain mode fixed gap wrong.");
    a_fix_seq: assert property (($rose(st_reg.st == BCG_GAP_FIX) && st_reg.cfg.seq_mode)
        |-> st_reg.fix_cnt == {1'b0, BCG_GAP_BASE_CYC} + {1'b0, BCG_SEQ_MODE_CYC} + {1'b0, st_reg.extra})
        else $error("Sequenced mode gap lacks ten cycles.");
    a_us_step: assert property ((st_reg.st == BCG_GAP_US && st_reg.us_cnt != 16'h0000)
        |=> st_reg.us_cnt == $past(st_reg.us_cnt) - ($past(us_tick) ? 16'h0001 : 16'h0000))
        else $error("Gap extension does not step once per microsecond.");
    a_timeout_limit: assert property (timeout_out
        |-> st_reg.to_cnt == bcg_to_ticks(st_reg.cfg.to_sel))
        else $error("Timeout fired at the wrong count.");
    a_timeout_flag: assert property (timeout_out |-> st_reg.to_flag)
        else $error("Timeout did not set the status flag.");

    c_prio_access: cover property (host_grant_out && in_sequence_out && st_reg.cfg.host_prio);
    c_seq_gap: cover property (gap_done_out && st_reg.cfg.seq_mode);
    c_timeout: cover property (timeout_out);
    c_ext_gap: cover property (gap_done_out && st_reg.cfg.gap_ext != 16'h0000);

endmodule // bcg_gap_timer

// ===== verif/bcg_rt_model.sv
// Remote terminal model that answers, or stays silent on, a controller command.
`timescale 1ns/100ps
module bcg_rt_model (
    // Clock
    input  wire logic        clk_in,
    // Controller side
    input  wire logic        resp_start_in,
    input  wire logic [11:0] dly_in,
    // Bus side
    output logic             resp_seen_out
);
    logic [11:0] cnt_reg = 12'h000;
    // A zero delay models a dead terminal, so the controller has to time out.
    always @(posedge clk_in) begin
        resp_seen_out <= (cnt_reg == 12'h001);
        if (resp_start_in)
            cnt_reg <= dly_in;
        else if (cnt_reg != 12'h000)
            cnt_reg <= cnt_reg - 12'h001;
    end
endmodule // bcg_rt_model

// ===== verif/bcg_message_gap_timing_tb_top.sv
// Self-checking testbench for the message gap timing block.
`timescale 1ns/100ps
module bcg_message_gap_timing_tb_top;
    import bcg_pkg::*;
    logic        clk_in = '0, rst_n_in = '0, awv = '0, wv = '0, bre = '0, arv = '0, rre = '0;
    logic        ms = '0, me = '0, hq = '0, rs = '0, awr, wrd, bv, arr, rv, sq, gd, gr, to, seen;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [11:0] dly = 12'h000;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0]  br, rr;
    int          errors = 0, compares = 0, l0, l1, g, n;
    int          tks[4] = '{37, 45, 101, 256}, mhz[4] = '{10, 12, 16, 20};
    initial forever #12.5 clk_in = ~clk_in;
    bcg_gap_timer uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rre), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .msg_start_in(ms),
        .msg_end_in(me), .in_sequence_out(sq), .gap_done_out(gd), .host_req_in(hq), .host_grant_out(gr),
        .resp_start_in(rs), .resp_seen_in(seen), .timeout_out(to));
    bcg_rt_model rt (.clk_in(clk_in), .resp_start_in(rs), .dly_in(dly), .resp_seen_out(seen));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task lim(input int m);
        if (n >= m) begin
            errors++;
            $display("ERROR wait expected answer seen none");
            final_report;
        end
    endtask
    // Handshakes are sampled mid-cycle so that releases land on the edge that took them.
    task axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tr, tb;
        logic [31:0] dv;
        logic [1:0] rb;
        @(posedge clk_in);
        {awv, wv, arv, bre, rre, awa, ara, wd} <= {w, w, !w, w, !w, a, a, d};
        for (n = 0; n < 50; n++) begin
            @(negedge clk_in);
            {ta, tw, tr, tb, dv, rb} = {awv & awr, wv & wrd, arv & arr, w ? bv : rv, rdat, w ? br : rr};
            @(posedge clk_in);
            {awv, wv, arv} <= {awv & !ta, wv & !tw, arv & !tr};
            if (tb) begin
                {bre, rre} <= 2'h0;
                break;
            end
        end
        lim(50);
        chk("resp", er, rb);
        if (!w)
            chk("rdata", d, dv);
    endtask
    // One message: opening run, message, closing run, then the gap up to its end pulse.
    task msg(input logic hreq, output int len);
        int p, op, cl, ps;
        {p, op, cl, ps, g, len} = '0;
        @(posedge clk_in);
        ms <= '1;
        @(posedge clk_in);
        ms <= '0;
        for (n = 0; n < 3000; n++) begin
            @(negedge clk_in);
            // A grant costs gap time when the sequence ran at the edge that decided it.
            g += (ps && gr);
            ps = sq;
            if (p == 3 && gd)
                break;
            len += (p == 3);
            cl += (p == 2 && sq);
            p = (p == 2 && !sq && cl > 0) ? 3 : p;
            op += (p == 0 && sq);
            p = (p == 0 && !sq && op > 0) ? 1 : p;
            @(posedge clk_in);
            {me, hq} <= {p == 1, hreq && sq && !gr};
            p = (p == 1) ? 2 : p;
        end
        lim(3000);
        chk("open_len", 7, op);
        chk("close_len", 5, cl);
    endtask
    task t_gap;
        msg('0, l0);
        axi('1, BCG_CTRL_OFS, 32'h1, BCG_RESP_OKAY);
        msg('0, l1);
        chk("seq_gap", l0 + 10, l1);
        axi('1, BCG_CTRL_OFS, 32'h0, BCG_RESP_OKAY);
        msg('1, l1);
        chk("held_grants", 0, g);
        chk("held_gap", l0, l1);
        axi('1, BCG_SETUP6_OFS, 32'h4000, BCG_RESP_OKAY);
        msg('1, l1);
        chk("grants", 1, g > 0);
        chk("host_gap", l0 + 6 * g, l1);
        axi('0, BCG_STATUS_OFS, 32'(6 * g << 8), BCG_RESP_OKAY);
        $display("test gap done");
    endtask
    task t_ext;
        for (int k = 0; k < 4; k++) begin
            axi('1, BCG_CTRL_OFS, 32'(k << 1), BCG_RESP_OKAY);
            axi('1, BCG_GAP_EXT_OFS, 32'h0, BCG_RESP_OKAY);
            msg('0, l0);
            axi('1, BCG_GAP_EXT_OFS, 32'h2, BCG_RESP_OKAY);
            msg('0, l1);
            chk("ext_gap", 1, l1 - l0 >= mhz[k] && l1 - l0 <= 2 * mhz[k] + 2);
        end
        $display("test extension done");
    endtask
    task wait_to(input logic [11:0] d);
        @(posedge clk_in);
        {rs, dly} <= {1'b1, d};
        @(posedge clk_in);
        rs <= '0;
        for (n = 0; n < 3000; n++) begin
            @(negedge clk_in);
            if (to)
                break;
        end
    endtask
    task t_tmo;
        for (int k = 0; k < 4; k++) begin
            axi('1, BCG_CTRL_OFS, 32'((k << 3) | 6), BCG_RESP_OKAY);
            wait_to(12'h000);
            chk("timeout", 1, n >= tks[k] * 10 - 12 && n <= tks[k] * 10 + 12);
        end
        axi('1, BCG_CTRL_OFS, 32'h6, BCG_RESP_OKAY);
        wait_to(12'h064);
        chk("answered", 3000, n);
        axi('0, BCG_STATUS_OFS, 32'h1, BCG_RESP_OKAY);
        axi('1, BCG_STATUS_OFS, 32'h1, BCG_RESP_OKAY);
        axi('0, BCG_STATUS_OFS, 32'h0, BCG_RESP_OKAY);
        $display("test timeout done");
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= '1;
        axi('0, BCG_CTRL_OFS, 32'h0, BCG_RESP_OKAY);
        axi('0, BCG_SETUP6_OFS, 32'h0, BCG_RESP_OKAY);
        axi('0, BCG_GAP_EXT_OFS, 32'h0, BCG_RESP_OKAY);
        axi('0, 8'h10, 32'h0, BCG_RESP_SLVERR);
        axi('1, 8'h10, 32'hFFFFFFFF, BCG_RESP_SLVERR);
        axi('1, BCG_GAP_EXT_OFS, 32'h0000FFFF, BCG_RESP_OKAY);
        axi('0, BCG_GAP_EXT_OFS, 32'h0000FFFF, BCG_RESP_OKAY);
        axi('1, BCG_GAP_EXT_OFS, 32'h0, BCG_RESP_OKAY);
        $display("test registers done");
        t_gap;
        t_ext;
        t_tmo;
        final_report;
    end
endmodule // bcg_message_gap_timing_tb_top
